// *** imb_pkg.sv ***
/*
  package for the imu output scheduler and built-in-test status block:
  register map, field positions, reset values, timing counts, carriers.
  assumes a 100 MHz clock and a simple strobe register port.
*/
package imb_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00; // rate, format, baud
  localparam logic [7:0] REG_FILTER   = 8'h04; // filter selects, orient
  localparam logic [7:0] REG_ALERT_EN = 8'h08; // alert enables
  localparam logic [7:0] REG_FAULT    = 8'h0C; // fault inputs seen
  localparam logic [7:0] REG_BIT      = 8'h10; // current test word
  localparam logic [7:0] REG_FETCH    = 8'h14; // write: fetch command
  localparam logic [7:0] REG_COUNT    = 8'h18; // packets sent

  // ------------------------------------------------------------------
  // field layout of control registers
  // ------------------------------------------------------------------
  localparam int CTRL_RATE_LSB   = 0;  // 3 bits
  localparam int CTRL_FMT_LSB    = 4;  // 2 bits
  localparam int CTRL_BAUD_LSB   = 8;  // 2 bits
  localparam int FILT_RATE_LSB   = 0;  // 2 bits
  localparam int FILT_ACC_LSB    = 2;  // 2 bits
  localparam int FILT_ORIENT_LSB = 8;  // 5 bits
  localparam int FETCH_KIND_LSB  = 0;  // 2 bits

  // test word bit positions
  localparam int BIT_FATAL   = 0;
  localparam int BIT_HW      = 1;
  localparam int BIT_LINK    = 2;
  localparam int BIT_SW      = 3;
  localparam int BIT_SUMMARY = 8;
  localparam int BIT_HW_AL   = 9;
  localparam int BIT_LINK_AL = 10;
  localparam int BIT_SW_AL   = 11;
  localparam int BIT_SENSOR  = 12;

  // alert enable bit positions
  localparam int EN_HW     = 0;
  localparam int EN_LINK   = 1;
  localparam int EN_SW     = 2;
  localparam int EN_SENSOR = 3;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_QUIET = 3'h0, RATE_100 = 3'h1, RATE_50 = 3'h2, RATE_25 = 3'h3,
    RATE_20 = 3'h4, RATE_10 = 3'h5, RATE_5 = 3'h6, RATE_2 = 3'h7
  } imb_rate_t;

  typedef enum logic [1:0] {
    PKT_SCALED_BASIC = 2'h0, PKT_SCALED_UNITS = 2'h1,
    PKT_DELTA = 2'h2, PKT_DIAG = 2'h3
  } imb_pkt_t;

  typedef enum logic [1:0] {
    BAUD_9600 = 2'h0, BAUD_19200 = 2'h1, BAUD_38400 = 2'h2,
    BAUD_57600 = 2'h3
  } imb_baud_t;

  typedef enum logic [1:0] {
    LPF_5 = 2'h0, LPF_10 = 2'h1, LPF_20 = 2'h2, LPF_50 = 2'h3
  } imb_lpf_t;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] RST_RATE     = 3'h1; // 100 Hz
  localparam logic [1:0] RST_FMT      = 2'h0; // basic scaled
  localparam logic [1:0] RST_BAUD     = 2'h2; // 38400
  localparam logic [1:0] RST_LPF      = 2'h2; // 20 Hz
  localparam logic [4:0] RST_ORIENT   = 5'h00;
  localparam logic [3:0] RST_ALERT_EN = 4'h8; // sensor alert only
  localparam int         NUM_ORIENT   = 24;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int SAMPLE_HZ     = 200;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ; // 500000
  // divisors of the 200 Hz tick per packet rate
  localparam logic [6:0] DIV_100 = 7'h02;
  localparam logic [6:0] DIV_50  = 7'h04;
  localparam logic [6:0] DIV_25  = 7'h08;
  localparam logic [6:0] DIV_20  = 7'h0A;
  localparam logic [6:0] DIV_10  = 7'h14;
  localparam logic [6:0] DIV_5   = 7'h28;
  localparam logic [6:0] DIV_2   = 7'h64;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } imb_bus_req_t;

  typedef struct packed {
    logic        valid;   // one-cycle send request
    imb_pkt_t    kind;
    logic [15:0] bit_word;
    logic [4:0]  orient;
  } imb_pkt_req_t;

endpackage

// *** imb_core.sv ***
/*
  imu output scheduler and built-in-test status: keeps the 200 Hz
  sample tick, accumulates delta counts, schedules packets at the
  selected rate or on fetch commands, and builds the test word.
  assumes fault and rate over-range inputs arrive from pins (triple
  sampled here) and that a serializer outside consumes pkt_* pulses.
*/
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module imb_core #(
  parameter int SAMPLE_CYCLES = imb_pkg::SAMPLE_CYCLES,
  parameter int DELTA_W       = 16
) (
  input  wire logic                 clk,          // 100 MHz clock
  input  wire logic                 rstn,         // sync reset, low
  input  wire imb_pkg::imb_bus_req_t bus,         // register request
  output logic [31:0]               rdata,        // read data, next cycle
  input  wire logic                 fatal_in,     // fatal fault pin
  input  wire logic                 hw_fault_in,  // hardware fault pin
  input  wire logic                 link_fault_in,// link fault pin
  input  wire logic                 sw_fault_in,  // software fault pin
  input  wire logic                 rate_ovr_in,  // rate sensor overrange
  input  wire logic                 acc_ovr_in,   // accel overrange, unused
  input  wire logic [DELTA_W-1:0]   delta_step,   // per-sample increment
  output logic                      sample_tick,  // 200 Hz sample pulse
  output imb_pkg::imb_pkt_req_t     pkt,          // packet send request
  output logic [DELTA_W-1:0]        delta_out,    // accumulated delta
  output logic [1:0]                baud_sel,     // link baud select
  output logic [1:0]                lpf_rate_sel, // rate filter cutoff
  output logic [1:0]                lpf_acc_sel   // accel filter cutoff
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]          rdata;
    logic [19:0]          samp_cnt;
    logic                 tick;
    logic [6:0]           pkt_cnt;
    logic [2:0]           rate;
    logic [1:0]           fmt;
    logic [1:0]           baud;
    logic [1:0]           lpf_rate;
    logic [1:0]           lpf_acc;
    logic [4:0]           orient;
    logic [3:0]           alert_en;
    logic [4:0]           s1;
    logic [4:0]           s2;
    logic [4:0]           s3;
    logic [4:0]           flt;
    logic [DELTA_W-1:0]   delta_acc;
    logic [DELTA_W-1:0]   delta_out;
    logic                 pend_fetch;
    logic [1:0]           pend_kind;
    logic [15:0]          bit_word;
    imb_pkg::imb_pkt_req_t pkt;
    logic [15:0]          pkt_count;
  } imb_state_t;

  imb_state_t st_r;
  imb_state_t st_nxt;

  logic [6:0]  div;
  logic [4:0]  raw;
  logic [15:0] word;
  logic        fire;
  logic        hw_a;
  logic        link_a;
  logic        sw_a;
  logic        sen_a;

  assign raw = {rate_ovr_in, sw_fault_in, link_fault_in, hw_fault_in,
                fatal_in};

  // ------------------------------------------------------------------
  // packet rate divisor
  // ------------------------------------------------------------------
  always_comb begin
    unique case (imb_pkg::imb_rate_t'(st_r.rate))
      imb_pkg::RATE_QUIET: div = 7'h00;
      imb_pkg::RATE_100:   div = imb_pkg::DIV_100;
      imb_pkg::RATE_50:    div = imb_pkg::DIV_50;
      imb_pkg::RATE_25:    div = imb_pkg::DIV_25;
      imb_pkg::RATE_20:    div = imb_pkg::DIV_20;
      imb_pkg::RATE_10:    div = imb_pkg::DIV_10;
      imb_pkg::RATE_5:     div = imb_pkg::DIV_5;
      imb_pkg::RATE_2:     div = imb_pkg::DIV_2;
    endcase
  end

  // ------------------------------------------------------------------
  // test word from filtered fault levels and enables
  // ------------------------------------------------------------------
  always_comb begin
    hw_a   = st_r.flt[1] & st_r.alert_en[imb_pkg::EN_HW];
    link_a = st_r.flt[2] & st_r.alert_en[imb_pkg::EN_LINK];
    sw_a   = st_r.flt[3] & st_r.alert_en[imb_pkg::EN_SW];
    // over-range follows the rate sensors only; accel pin ignored
    sen_a  = st_r.flt[4] & st_r.alert_en[imb_pkg::EN_SENSOR];
    word = 16'h0000;
    word[imb_pkg::BIT_FATAL]   = st_r.flt[0];
    word[imb_pkg::BIT_HW]      = st_r.flt[1];
    word[imb_pkg::BIT_LINK]    = st_r.flt[2];
    word[imb_pkg::BIT_SW]      = st_r.flt[3];
    word[imb_pkg::BIT_HW_AL]   = hw_a;
    word[imb_pkg::BIT_LINK_AL] = link_a;
    word[imb_pkg::BIT_SW_AL]   = sw_a;
    word[imb_pkg::BIT_SENSOR]  = sen_a;
    word[imb_pkg::BIT_SUMMARY] = hw_a | link_a | sw_a | sen_a;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.pkt.valid = 1'b0;
    fire = 1'b0;
    // pin filter: change accepted once stages two and three agree
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 5; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.flt[i] = st_r.s3[i];
      end
    end
    st_nxt.bit_word = word;

    // fixed sample tick, independent of packet rate
    if (st_r.samp_cnt == 20'(SAMPLE_CYCLES - 1)) begin
      st_nxt.samp_cnt = 20'h00000;
      st_nxt.tick = 1'b1;
      st_nxt.delta_acc = st_r.delta_acc + delta_step;
    end else begin
      st_nxt.samp_cnt = st_r.samp_cnt + 20'h00001;
    end

    // periodic scheduling on the sample tick
    if (st_r.tick && div != 7'h00) begin
      if (st_r.pkt_cnt + 7'h01 >= div) begin
        st_nxt.pkt_cnt = 7'h00;
        fire = 1'b1;
      end else begin
        st_nxt.pkt_cnt = st_r.pkt_cnt + 7'h01;
      end
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        imb_pkg::REG_CTRL: begin
          st_nxt.rate = bus.wdata[imb_pkg::CTRL_RATE_LSB +: 3];
          st_nxt.fmt  = bus.wdata[imb_pkg::CTRL_FMT_LSB +: 2];
          st_nxt.baud = bus.wdata[imb_pkg::CTRL_BAUD_LSB +: 2];
          st_nxt.pkt_cnt = 7'h00;
        end
        imb_pkg::REG_FILTER: begin
          st_nxt.lpf_rate = bus.wdata[imb_pkg::FILT_RATE_LSB +: 2];
          st_nxt.lpf_acc  = bus.wdata[imb_pkg::FILT_ACC_LSB +: 2];
          // out-of-range orientation codes are refused
          if (bus.wdata[imb_pkg::FILT_ORIENT_LSB +: 5] <
              5'(imb_pkg::NUM_ORIENT)) begin
            st_nxt.orient = bus.wdata[imb_pkg::FILT_ORIENT_LSB +: 5];
          end
        end
        imb_pkg::REG_ALERT_EN: st_nxt.alert_en = bus.wdata[3:0];
        imb_pkg::REG_FETCH: begin
          st_nxt.pend_fetch = 1'b1;
          st_nxt.pend_kind = bus.wdata[imb_pkg::FETCH_KIND_LSB +: 2];
        end
        default: ;
      endcase
    end

    // polled packets win the slot; a colliding periodic one is dropped
    if (st_r.pend_fetch) begin
      // a fetch written in this same cycle stays pending: set wins
      st_nxt.pend_fetch = bus.wr && bus.addr == imb_pkg::REG_FETCH;
      st_nxt.pkt.valid = 1'b1;
      st_nxt.pkt.kind = imb_pkg::imb_pkt_t'(st_r.pend_kind);
      if (imb_pkg::imb_pkt_t'(st_r.pend_kind) == imb_pkg::PKT_DELTA) begin
        // snapshot and restart so the next poll sees a fresh span
        st_nxt.delta_out = st_nxt.delta_acc;
        st_nxt.delta_acc = '0;
      end
    end else if (fire) begin
      st_nxt.pkt.valid = 1'b1;
      st_nxt.pkt.kind = imb_pkg::imb_pkt_t'(st_r.fmt);
      if (imb_pkg::imb_pkt_t'(st_r.fmt) == imb_pkg::PKT_DELTA) begin
        st_nxt.delta_out = st_nxt.delta_acc;
        st_nxt.delta_acc = '0;
      end
    end
    if (st_nxt.pkt.valid) begin
      st_nxt.pkt.bit_word = word;
      st_nxt.pkt.orient = st_r.orient;
      st_nxt.pkt_count = st_r.pkt_count + 16'h0001;
    end

    // reads
    st_nxt.rdata = 32'h00000000;
    if (bus.rd) begin
      unique case (bus.addr)
        imb_pkg::REG_CTRL:
          st_nxt.rdata = {22'h000000, st_r.baud, 2'h0, st_r.fmt,
                          1'b0, st_r.rate};
        imb_pkg::REG_FILTER:
          st_nxt.rdata = {19'h00000, st_r.orient, 4'h0, st_r.lpf_acc,
                          st_r.lpf_rate};
        imb_pkg::REG_ALERT_EN: st_nxt.rdata = {28'h0000000, st_r.alert_en};
        imb_pkg::REG_FAULT:    st_nxt.rdata = {27'h0000000, st_r.flt};
        imb_pkg::REG_BIT:      st_nxt.rdata = {16'h0000, st_r.bit_word};
        imb_pkg::REG_COUNT:    st_nxt.rdata = {16'h0000, st_r.pkt_count};
        default:               st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.rate <= imb_pkg::RST_RATE;
      st_r.fmt <= imb_pkg::RST_FMT;
      st_r.baud <= imb_pkg::RST_BAUD;
      st_r.lpf_rate <= imb_pkg::RST_LPF;
      st_r.lpf_acc <= imb_pkg::RST_LPF;
      st_r.orient <= imb_pkg::RST_ORIENT;
      st_r.alert_en <= imb_pkg::RST_ALERT_EN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata        = st_r.rdata;
  assign sample_tick  = st_r.tick;
  assign pkt          = st_r.pkt;
  assign delta_out    = st_r.delta_out;
  assign baud_sel     = st_r.baud;
  assign lpf_rate_sel = st_r.lpf_rate;
  assign lpf_acc_sel  = st_r.lpf_acc;

endmodule

// *** imb_monitor.sv ***
/*
  checker for imb_core: packet timing, test word layout, sample tick
  spacing and reset levels. sees only the imb_core ports.
*/
`timescale 1ns/1ns
module imb_monitor #(
  parameter int SAMPLE_CYCLES = imb_pkg::SAMPLE_CYCLES
) (
  input wire logic                  clk,           // clock
  input wire logic                  rstn,          // sync reset, low
  input wire imb_pkg::imb_bus_req_t bus,           // register request
  input wire logic                  fatal_in,      // fatal pin
  input wire logic                  hw_fault_in,   // hw pin
  input wire logic                  link_fault_in, // link pin
  input wire logic                  sw_fault_in,   // sw pin
  input wire logic                  rate_ovr_in,   // rate overrange
  input wire logic                  sample_tick,   // sample pulse
  input wire imb_pkg::imb_pkt_req_t pkt,           // packet request
  input wire logic [1:0]            baud_sel,      // baud select
  input wire logic [1:0]            lpf_rate_sel,  // rate cutoff
  input wire logic [1:0]            lpf_acc_sel    // accel cutoff
);
  // --------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------
  logic        fetch;
  logic [3:0]  flt;
  logic [31:0] gap_r;
  logic        seen_r;
  assign fetch = bus.wr && bus.addr == imb_pkg::REG_FETCH;
  assign flt   = {sw_fault_in, link_fault_in, hw_fault_in, fatal_in};
  // gap only means something once a first tick has been seen
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gap_r  <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= sample_tick ? 32'h0 : gap_r + 32'h1;
      seen_r <= seen_r | sample_tick;
    end
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_fetch_to_pkt: assert property (fetch |-> ##2 pkt.valid)
    else $error("fetch not answered after two cycles");
  a_fetch_kind: assert property (fetch ##1 !fetch |=>
    pkt.kind == $past(bus.wdata[1:0], 2))
    else $error("packet kind differs from fetched kind");
  a_reserved_zero: assert property (pkt.valid |->
    pkt.bit_word[7:4] == 4'h0 && pkt.bit_word[15:13] == 3'h0)
    else $error("reserved test word bits set");
  a_summary_or: assert property (pkt.valid |->
    pkt.bit_word[8] == |pkt.bit_word[12:9])
    else $error("summary alert disagrees with alert bits");
  a_fault_bits: assert property ($stable(flt)[*8] ##0 pkt.valid |->
    pkt.bit_word[3:0] == flt)
    else $error("error byte does not follow fault pins");
  a_accel_ignored: assert property ((!rate_ovr_in)[*8] ##0 pkt.valid |->
    !pkt.bit_word[imb_pkg::BIT_SENSOR])
    else $error("overrange flagged without rate overrange");
  a_tick_spacing: assert property (sample_tick && seen_r |->
    gap_r == SAMPLE_CYCLES - 1)
    else $error("sample tick spacing wrong");
  a_tick_due: assert property (seen_r |-> gap_r < SAMPLE_CYCLES)
    else $error("sample tick overdue");
  a_reset_levels: assert property ($rose(rstn) |->
    baud_sel == imb_pkg::RST_BAUD && lpf_rate_sel == imb_pkg::RST_LPF
    && lpf_acc_sel == imb_pkg::RST_LPF)
    else $error("config levels wrong after reset");
endmodule
bind imb_core imb_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mon_u (
  .clk(clk), .rstn(rstn), .bus(bus), .fatal_in(fatal_in),
  .hw_fault_in(hw_fault_in), .link_fault_in(link_fault_in),
  .sw_fault_in(sw_fault_in), .rate_ovr_in(rate_ovr_in),
  .sample_tick(sample_tick), .pkt(pkt), .baud_sel(baud_sel),
  .lpf_rate_sel(lpf_rate_sel), .lpf_acc_sel(lpf_acc_sel));

// *** imb_host.sv ***
/*
  host-side model: takes packet requests off the link and counts them.
  assumes the device's packet pulses stand for one clock each.
*/
`timescale 1ns/1ns
module imb_host #(
  parameter logic [1:0] HOST_BAUD = 2'h2
) (
  input  wire logic                  clk,      // clock
  input  wire logic                  rstn,     // sync reset, low
  input  wire imb_pkg::imb_pkt_req_t pkt,      // packet from device
  input  wire logic [1:0]            baud_sel, // device baud select
  output logic [31:0]                rx_cnt,   // packets received
  output logic                       baud_ok   // both ends agree
);
  // a host at another rate hears only garbage, so nothing is counted
  assign baud_ok = baud_sel == HOST_BAUD;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_cnt <= 32'h0;
    end else if (pkt.valid && baud_ok) begin
      rx_cnt <= rx_cnt + 32'h1;
    end
  end
endmodule

// *** tb_imu_output_and_bit_status.sv ***
/*
  testbench for imb_core: register port, periodic and polled packets,
  delta snapshots and the test word. needs imb_host and imb_monitor.
*/
`timescale 1ns/1ns
module tb_imu_output_and_bit_status;
  localparam int SC = 20;
  logic                  clk;
  logic                  rstn;
  imb_pkg::imb_bus_req_t bus;
  imb_pkg::imb_pkt_req_t pkt;
  logic [31:0]           rdata;
  logic [31:0]           rx_cnt;
  logic [31:0]           c0;
  logic [5:0]            pins;
  logic [15:0]           step;
  logic [15:0]           dout;
  logic [1:0]            baud, lpfr, lpfa, fmt, fmt_q;
  logic [3:0]            en;
  logic                  tick, baud_ok, rd_d, pchk, pw;
  logic [34:0]           pe;
  logic [31:0]           rq[$];
  logic [34:0]           pq[$];
  int                    fails, n_checks;
  int                    hz[8] = '{0, 100, 50, 25, 20, 10, 5, 2};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  imb_core #(.SAMPLE_CYCLES(SC), .DELTA_W(16)) dut_u (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .fatal_in(pins[0]), .hw_fault_in(pins[1]), .link_fault_in(pins[2]),
    .sw_fault_in(pins[3]), .rate_ovr_in(pins[4]), .acc_ovr_in(pins[5]),
    .delta_step(step), .sample_tick(tick), .pkt(pkt), .delta_out(dout),
    .baud_sel(baud), .lpf_rate_sel(lpfr), .lpf_acc_sel(lpfa));
  imb_host host_u (.clk(clk), .rstn(rstn), .pkt(pkt), .baud_sel(baud),
    .rx_cnt(rx_cnt), .baud_ok(baud_ok));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read: d is the expected data, compared by the watcher
  task automatic op(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) rq.push_back(d);
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  function automatic logic [15:0] bw();
    logic [3:0] al;
    al = {pins[4], pins[3:1]} & en;
    return {3'h0, al, |al, 4'h0, pins[3:0]};
  endfunction
  // strobe is left high so fetches can run back to back
  task automatic fetch(input logic [1:0] k, input logic c,
                       input logic [15:0] dl);
    pq.push_back({k, bw(), c, dl});
    bus <= '{addr: imb_pkg::REG_FETCH, wdata: {30'h0, k}, wr: 1'b1,
             rd: 1'b0};
    cyc(1);
  endtask
  task automatic drain();
    for (int i = 0; i < 60 && pq.size() > 0; i++) cyc(1);
    if (pq.size() > 0) begin
      fails++;
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= bus.rd;
    if (rd_d && rq.size() > 0) chk(rdata, rq.pop_front());
    if (pkt.valid && pchk) begin
      pe = pq.size() > 0 ? pq.pop_front() : '1;
      chk({30'h0, pkt.kind}, {30'h0, pe[34:33]});
      chk({16'h0, pkt.bit_word}, {16'h0, pe[32:17]});
      chk({27'h0, pkt.orient}, 32'h0000_0017);
      if (pe[16]) chk({16'h0, dout}, {16'h0, pe[15:0]});
    end else if (pkt.valid && pw) begin
      chk({30'h0, pkt.kind}, {30'h0, fmt_q});
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    bus = '0;
    pins = 6'h00;
    step = 16'h0000;
    en = 4'h8;
    {pchk, pw, fmt_q} = 4'h0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'h3D14D585));
    cyc(4);
    rstn <= 1'b1;
    cyc(1);
    chk({26'h0, baud, lpfr, lpfa}, 32'h0000_002A);
    op(1'b0, imb_pkg::REG_CTRL, 32'h0000_0201);
    op(1'b0, imb_pkg::REG_FILTER, 32'h0000_000A);
    op(1'b0, imb_pkg::REG_ALERT_EN, 32'h0000_0008);
    op(1'b0, imb_pkg::REG_FETCH, 32'h0000_0000);
    op(1'b0, 8'h1C, 32'h0000_0000);
    op(1'b0, imb_pkg::REG_COUNT, 32'h0000_0000);
    $display("reset values test ended");
    op(1'b1, imb_pkg::REG_FILTER, 32'h0000_1709);
    op(1'b1, imb_pkg::REG_FILTER, 32'h0000_1807);
    op(1'b0, imb_pkg::REG_FILTER, 32'h0000_1707);
    chk({28'h0, lpfa, lpfr}, 32'h0000_0007);
    for (int b = 0; b < 4; b++) begin
      op(1'b1, imb_pkg::REG_CTRL, 32'(b) << 8);
      chk({30'h0, baud}, 32'(b));
      chk({31'h0, baud_ok}, {31'h0, b == 2});
    end
    $display("filter and baud test ended");
    for (int r = 0; r < 8; r++) begin
      fmt = 2'($urandom % 4);
      pw <= 1'b0;
      op(1'b1, imb_pkg::REG_CTRL, {22'h0, 2'h2, 2'h0, fmt, 1'b0, 3'(r)});
      fmt_q <= fmt;
      pw <= 1'b1;
      c0 = rx_cnt;
      cyc(200 * SC);
      chk(rx_cnt - c0, 32'(hz[r]));
    end
    pw <= 1'b0;
    $display("packet rate test ended");
    step <= 16'($urandom);
    pchk <= 1'b1;
    op(1'b1, imb_pkg::REG_CTRL, 32'h0000_0200);
    cyc(3 * SC);
    fmt = 2'($urandom % 4);
    for (int i = 0; i < 4; i++) fetch(2'(i) + fmt, 1'b0, 16'h0);
    bus <= '0;
    drain();
    fetch(2'h2, 1'b0, 16'h0);
    bus <= '0;
    cyc(7 * SC - 1);
    fetch(2'h2, 1'b1, 16'(7 * step));
    bus <= '0;
    drain();
    $display("polled packet test ended");
    for (int i = 0; i < 16; i++) begin
      pins <= 6'($urandom);
      en = 4'(i);
      op(1'b1, imb_pkg::REG_ALERT_EN, 32'(i));
      cyc(8);
      op(1'b0, imb_pkg::REG_FAULT, {27'h0, pins[4:0]});
      op(1'b0, imb_pkg::REG_BIT, {16'h0, bw()});
      fetch(2'h3, 1'b0, 16'h0);
      bus <= '0;
      drain();
    end
    en = 4'h8;
    op(1'b1, imb_pkg::REG_ALERT_EN, 32'h0000_0008);
    $display("test word test ended");
    summarize();
  end
endmodule
